// File: ple_pkg.sv
// Purpose: Constants and types for the postfix logic equation engine
// Assumes: One 16-bit parameter word per list entry, opcode in the top bits
// Notes:   Index fields carry the user-facing numbers (flags 1..64)
package ple_pkg;

   // ****************************************************
   // List geometry
   // ****************************************************
   localparam int unsigned PROG_DEPTH = 512;
   localparam int unsigned ADDR_W = 9;
   localparam logic [8:0] LAST_ADDR = 9'h1ff;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned OP_MSB = 15;
   localparam int unsigned OP_LSB = 11;
   localparam int unsigned ARG_MSB = 10;

   // ****************************************************
   // Resource counts
   // ****************************************************
   localparam int unsigned FLAG_COUNT = 64;
   localparam int unsigned INPUT_COUNT = 64;
   localparam int unsigned CONTACT_COUNT = 16;
   localparam int unsigned LATCH_COUNT = 32;
   localparam int unsigned TIMER_COUNT = 32;
   localparam int unsigned STACK_DEPTH = 32;
   localparam int unsigned DEPTH_W = 6;
   localparam logic [5:0] DEPTH_MAX = 6'h20;
   localparam logic [10:0] GATE_MIN = 11'h002;
   localparam logic [10:0] GATE_MAX = 11'h010;
   localparam logic [5:0] XOR_INPUTS = 6'h02;
   localparam logic [5:0] LATCH_INPUTS = 6'h02;
   localparam logic [10:0] FLAG_LAST = 11'h040;
   localparam logic [10:0] TIMER_LAST = 11'h020;
   localparam logic [10:0] INPUT_LAST = 11'h03f;
   localparam logic [10:0] CONTACT_LAST = 11'h00f;
   localparam logic [10:0] LATCH_LAST = 11'h01f;

   // ****************************************************
   // Parameter word opcodes
   // ****************************************************
   localparam logic [4:0] OPC_END = 5'h00;
   localparam logic [4:0] OPC_ON = 5'h01;
   localparam logic [4:0] OPC_OFF = 5'h02;
   localparam logic [4:0] OPC_INPUT = 5'h03;
   localparam logic [4:0] OPC_CONTACT = 5'h04;
   localparam logic [4:0] OPC_FLAG = 5'h05;
   localparam logic [4:0] OPC_NOT = 5'h06;
   localparam logic [4:0] OPC_OR = 5'h07;
   localparam logic [4:0] OPC_AND = 5'h08;
   localparam logic [4:0] OPC_NOR = 5'h09;
   localparam logic [4:0] OPC_NAND = 5'h0a;
   localparam logic [4:0] OPC_XOR = 5'h0b;
   localparam logic [4:0] OPC_LATCH = 5'h0c;
   localparam logic [4:0] OPC_POS_SHOT = 5'h0d;
   localparam logic [4:0] OPC_NEG_SHOT = 5'h0e;
   localparam logic [4:0] OPC_DUAL_SHOT = 5'h0f;
   localparam logic [4:0] OPC_TIMER = 5'h10;
   localparam logic [4:0] OPC_ASSIGN = 5'h11;

   typedef enum logic [1:0] {PLE_IDLE, PLE_CHECK, PLE_EVAL} ple_state_e;

endpackage

// File: ple_engine.sv
// Purpose: Evaluates a postfix list of boolean parameters on an operand stack
// Assumes: Settings store writes the list; pins are asynchronous to clock
// Notes:   Timers pass their input straight through; delays live elsewhere
//
// Summary of operation
// - Each operator yields one boolean result
// - Assignment ends the current equation
// - Duplicate timer or assignment flags syntax error
// - Parameters evaluated strictly in list order
// - Latch holds set state across passes
// - Latches clear on power-up reset
// - Any new setting recompiles and clears latches
// - Result flags 1 to 64, one writer each
// - Gate of N inputs takes N previous results
// - Inversion complements the single previous result
// - Contact on-state selectable open or closed
// - Gates take 2 to 16, XOR exactly 2
// - Latch reset-dominant: reset last, set before
// - First end marker stops evaluation
// - One-shot true for exactly one pass
`timescale 1ns/1ps
`default_nettype none
module ple_engine (
   input wire logic clock,
   input wire logic rst,
   input wire logic cfg_we,
   input wire logic [8:0] cfg_addr,
   input wire logic [15:0] cfg_data,
   input wire logic eval_start,
   input wire logic [63:0] input_states,
   input wire logic [15:0] contact_raw,
   input wire logic [15:0] contact_on_state,
   output logic [63:0] internal_result_flag,
   output logic busy,
   output logic pass_done,
   output logic syntax_error
);

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [5:0] pops_of(input logic [15:0] w);
      logic [4:0] op;
      op = w[ple_pkg::OP_MSB:ple_pkg::OP_LSB];
      case (op)
         ple_pkg::OPC_OR, ple_pkg::OPC_AND, ple_pkg::OPC_NOR,
         ple_pkg::OPC_NAND: pops_of = {1'b0, w[4:0]};
         ple_pkg::OPC_XOR: pops_of = ple_pkg::XOR_INPUTS;
         ple_pkg::OPC_LATCH: pops_of = ple_pkg::LATCH_INPUTS;
         ple_pkg::OPC_NOT, ple_pkg::OPC_POS_SHOT, ple_pkg::OPC_NEG_SHOT,
         ple_pkg::OPC_DUAL_SHOT, ple_pkg::OPC_TIMER,
         ple_pkg::OPC_ASSIGN: pops_of = 6'h01;
         default: pops_of = 6'h00;
      endcase
   endfunction

   function automatic logic [5:0] pushes_of(input logic [15:0] w);
      logic [4:0] op;
      op = w[ple_pkg::OP_MSB:ple_pkg::OP_LSB];
      pushes_of = (op == ple_pkg::OPC_ASSIGN) ? 6'h00 : 6'h01;
   endfunction

   // Malformed word: unknown opcode or index out of range
   function automatic logic bad_word(input logic [15:0] w);
      logic [4:0] op;
      logic [10:0] a;
      op = w[ple_pkg::OP_MSB:ple_pkg::OP_LSB];
      a = w[ple_pkg::ARG_MSB:0];
      case (op)
         ple_pkg::OPC_END, ple_pkg::OPC_ON, ple_pkg::OPC_OFF,
         ple_pkg::OPC_NOT, ple_pkg::OPC_XOR: bad_word = 1'b0;
         ple_pkg::OPC_INPUT: bad_word = a > ple_pkg::INPUT_LAST;
         ple_pkg::OPC_CONTACT: bad_word = a > ple_pkg::CONTACT_LAST;
         ple_pkg::OPC_FLAG, ple_pkg::OPC_ASSIGN:
            bad_word = (a == 11'h000) || (a > ple_pkg::FLAG_LAST);
         ple_pkg::OPC_OR, ple_pkg::OPC_AND, ple_pkg::OPC_NOR,
         ple_pkg::OPC_NAND:
            bad_word = (a < ple_pkg::GATE_MIN) || (a > ple_pkg::GATE_MAX);
         ple_pkg::OPC_LATCH, ple_pkg::OPC_POS_SHOT, ple_pkg::OPC_NEG_SHOT,
         ple_pkg::OPC_DUAL_SHOT: bad_word = a > ple_pkg::LATCH_LAST;
         ple_pkg::OPC_TIMER:
            bad_word = (a == 11'h000) || (a > ple_pkg::TIMER_LAST);
         default: bad_word = 1'b1;
      endcase
   endfunction

   // Top of stack is bit 0; only the low n bits take part
   function automatic logic gate_eval(input logic [4:0] op,
                                      input logic [31:0] stk,
                                      input logic [5:0] n);
      logic [31:0] m;
      m = ~(32'hffffffff << n);
      case (op)
         ple_pkg::OPC_OR: gate_eval = |(stk & m);
         ple_pkg::OPC_AND: gate_eval = &(stk | ~m);
         ple_pkg::OPC_NOR: gate_eval = ~|(stk & m);
         ple_pkg::OPC_NAND: gate_eval = ~&(stk | ~m);
         ple_pkg::OPC_XOR: gate_eval = stk[0] ^ stk[1];
         default: gate_eval = 1'b0;
      endcase
   endfunction

   // ****************************************************
   // Program store and pin synchronisers
   // ****************************************************
   logic [15:0] prog_mem [0:511];
   logic [63:0] in_meta_r, in_sync_r;
   logic [15:0] ct_meta_r, ct_sync_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ple_pkg::PROG_DEPTH; i++) begin
            prog_mem[i] <= 16'h0000;
         end
      end else if (cfg_we) begin
         prog_mem[cfg_addr] <= cfg_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         in_meta_r <= 64'h0;
         in_sync_r <= 64'h0;
         ct_meta_r <= 16'h0;
         ct_sync_r <= 16'h0;
      end else begin
         in_meta_r <= input_states;
         in_sync_r <= in_meta_r;
         ct_meta_r <= contact_raw;
         ct_sync_r <= ct_meta_r;
      end
   end

   // ****************************************************
   // Sequencer state
   // ****************************************************
   ple_pkg::ple_state_e state_r, state_nxt;
   logic [8:0] pc_r, pc_nxt;
   logic [5:0] depth_r, depth_nxt;
   logic [31:0] stk_r, stk_nxt;
   logic [63:0] flags_r, flags_nxt;
   logic [31:0] latch_r, latch_nxt;
   logic [31:0] shot_prev_r, shot_prev_nxt;
   logic [31:0] used_tmr_r, used_tmr_nxt;
   logic [63:0] used_asg_r, used_asg_nxt;
   logic dirty_r, dirty_nxt, err_r, err_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt;

   logic [15:0] word;
   logic [4:0] op;
   logic [5:0] idx, flag_idx;
   logic [5:0] n_pop;
   logic [31:0] popped;
   logic last_entry;
   logic res, shot_in;

   assign word = prog_mem[pc_r];
   assign op = word[ple_pkg::OP_MSB:ple_pkg::OP_LSB];
   assign idx = word[5:0];
   assign flag_idx = 6'(word[6:0] - 7'h01);
   assign n_pop = pops_of(word);
   assign popped = stk_r >> n_pop;
   assign last_entry = (pc_r == ple_pkg::LAST_ADDR);

   always_comb begin
      state_nxt = state_r;
      pc_nxt = pc_r;
      depth_nxt = depth_r;
      stk_nxt = stk_r;
      flags_nxt = flags_r;
      latch_nxt = latch_r;
      shot_prev_nxt = shot_prev_r;
      used_tmr_nxt = used_tmr_r;
      used_asg_nxt = used_asg_r;
      dirty_nxt = dirty_r;
      err_nxt = err_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      res = 1'b0;
      shot_in = stk_r[0];
      case (state_r)
         ple_pkg::PLE_IDLE: begin
            if (eval_start) begin
               pc_nxt = 9'h000;
               depth_nxt = 6'h00;
               stk_nxt = 32'h0;
               if (dirty_r) begin
                  state_nxt = ple_pkg::PLE_CHECK;
                  used_tmr_nxt = 32'h0;
                  used_asg_nxt = 64'h0;
                  err_nxt = 1'b0;
                  busy_nxt = 1'b1;
               end else if (!err_r) begin
                  state_nxt = ple_pkg::PLE_EVAL;
                  busy_nxt = 1'b1;
               end else begin
                  // A list with a syntax error is never evaluated
                  done_nxt = 1'b1;
               end
            end
         end
         ple_pkg::PLE_CHECK: begin
            if (op == ple_pkg::OPC_END) begin
               dirty_nxt = 1'b0;
               pc_nxt = 9'h000;
               depth_nxt = 6'h00;
               state_nxt = err_r ? ple_pkg::PLE_IDLE : ple_pkg::PLE_EVAL;
               busy_nxt = !err_r;
               done_nxt = err_r;
            end else begin
               if (bad_word(word)) begin
                  err_nxt = 1'b1;
               end
               if (depth_r < n_pop) begin
                  err_nxt = 1'b1;
               end
               if (depth_r - n_pop + pushes_of(word) > ple_pkg::DEPTH_MAX) begin
                  err_nxt = 1'b1;
               end
               if (op == ple_pkg::OPC_TIMER) begin
                  used_tmr_nxt[5'(flag_idx)] = 1'b1;
                  if (used_tmr_r[5'(flag_idx)]) begin
                     err_nxt = 1'b1;
                  end
               end
               if (op == ple_pkg::OPC_ASSIGN) begin
                  used_asg_nxt[flag_idx] = 1'b1;
                  if (used_asg_r[flag_idx]) begin
                     err_nxt = 1'b1;
                  end
                  depth_nxt = 6'h00;
               end else begin
                  depth_nxt = depth_r - n_pop + pushes_of(word);
               end
               pc_nxt = 9'(pc_r + 9'h001);
               if (last_entry) begin
                  // Running off the list without an end marker is a syntax error
                  dirty_nxt = 1'b1;
                  err_nxt = 1'b1;
                  state_nxt = ple_pkg::PLE_IDLE;
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
         end
         ple_pkg::PLE_EVAL: begin
            // One word per clock, in list order
            pc_nxt = 9'(pc_r + 9'h001);
            depth_nxt = 6'(depth_r - n_pop + pushes_of(word));
            case (op)
               ple_pkg::OPC_ON: res = 1'b1;
               ple_pkg::OPC_OFF: res = 1'b0;
               ple_pkg::OPC_INPUT: res = in_sync_r[idx];
               ple_pkg::OPC_CONTACT:
                  res = ct_sync_r[idx[3:0]] ~^ contact_on_state[idx[3:0]];
               ple_pkg::OPC_FLAG: res = flags_r[flag_idx];
               ple_pkg::OPC_NOT: res = ~stk_r[0];
               ple_pkg::OPC_OR, ple_pkg::OPC_AND, ple_pkg::OPC_NOR,
               ple_pkg::OPC_NAND, ple_pkg::OPC_XOR:
                  res = gate_eval(op, stk_r, n_pop);
               ple_pkg::OPC_LATCH: begin
                  res = ~stk_r[0] & (stk_r[1] | latch_r[idx[4:0]]);
                  latch_nxt[idx[4:0]] = res;
               end
               ple_pkg::OPC_POS_SHOT, ple_pkg::OPC_NEG_SHOT,
               ple_pkg::OPC_DUAL_SHOT: begin
                  shot_prev_nxt[idx[4:0]] = shot_in;
                  res = (op != ple_pkg::OPC_NEG_SHOT) &&
                        shot_in && !shot_prev_r[idx[4:0]];
                  res = res || ((op != ple_pkg::OPC_POS_SHOT) &&
                        !shot_in && shot_prev_r[idx[4:0]]);
               end
               ple_pkg::OPC_TIMER: res = stk_r[0];
               default: res = 1'b0;
            endcase
            stk_nxt = {popped[30:0], res};
            if (op == ple_pkg::OPC_ASSIGN) begin
               flags_nxt[flag_idx] = stk_r[0];
               depth_nxt = 6'h00;
               stk_nxt = 32'h0;
            end
            if (op == ple_pkg::OPC_END || last_entry) begin
               state_nxt = ple_pkg::PLE_IDLE;
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               stk_nxt = stk_r;
               depth_nxt = depth_r;
               flags_nxt = flags_r;
               latch_nxt = latch_r;
               shot_prev_nxt = shot_prev_r;
            end
         end
         default: begin
            state_nxt = ple_pkg::PLE_IDLE;
            busy_nxt = 1'b0;
         end
      endcase
      // A new setting wins over any pass under way
      if (cfg_we) begin
         state_nxt = ple_pkg::PLE_IDLE;
         dirty_nxt = 1'b1;
         latch_nxt = 32'h0;
         shot_prev_nxt = 32'h0;
         busy_nxt = 1'b0;
         done_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= ple_pkg::PLE_IDLE;
         pc_r <= 9'h000;
         depth_r <= 6'h00;
         stk_r <= 32'h0;
         flags_r <= 64'h0;
         latch_r <= 32'h0;
         shot_prev_r <= 32'h0;
         used_tmr_r <= 32'h0;
         used_asg_r <= 64'h0;
         dirty_r <= 1'b1;
         err_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         depth_r <= depth_nxt;
         stk_r <= stk_nxt;
         flags_r <= flags_nxt;
         latch_r <= latch_nxt;
         shot_prev_r <= shot_prev_nxt;
         used_tmr_r <= used_tmr_nxt;
         used_asg_r <= used_asg_nxt;
         dirty_r <= dirty_nxt;
         err_r <= err_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign internal_result_flag = flags_r;
   assign busy = busy_r;
   assign pass_done = done_r;
   assign syntax_error = err_r;

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic in_eval, in_check;
   assign in_eval = (state_r == ple_pkg::PLE_EVAL) && !cfg_we;
   assign in_check = (state_r == ple_pkg::PLE_CHECK) && !cfg_we;

   sequence s_eval_op(logic [4:0] o);
      in_eval && (op == o) && !last_entry;
   endsequence

   dup_assign_a: assert property (in_check && op == ple_pkg::OPC_ASSIGN && used_asg_r[flag_idx] |=> err_r) else $error("duplicate assignment not flagged");
   underflow_a: assert property (in_check && op != ple_pkg::OPC_END && depth_r < n_pop |=> err_r) else $error("stack underflow not flagged");
   latch_clear_a: assert property (cfg_we |=> latch_r == 32'h0 && !busy_r) else $error("latches kept across new setting");
   list_order_a: assert property (in_eval ##1 state_r == ple_pkg::PLE_EVAL |-> pc_r == $past(pc_r) + 9'h001) else $error("list entry skipped");
   end_stop_a: assert property (in_eval && op == ple_pkg::OPC_END |=> !busy_r && pass_done ##1 !pass_done) else $error("end marker did not stop pass");
   assign_end_a: assert property (s_eval_op(ple_pkg::OPC_ASSIGN) |=> depth_r == 6'h00 && flags_r[$past(flag_idx)] == $past(stk_r[0])) else $error("assignment did not close equation");
   gate_pop_a: assert property (s_eval_op(ple_pkg::OPC_AND) |=> depth_r == $past(depth_r) - $past(n_pop) + 6'h01) else $error("gate consumed wrong count");
   invert_a: assert property (s_eval_op(ple_pkg::OPC_NOT) |=> stk_r[0] != $past(stk_r[0]) && depth_r == $past(depth_r)) else $error("inversion wrong");
   latch_reset_a: assert property (s_eval_op(ple_pkg::OPC_LATCH) && stk_r[0] |=> !stk_r[0]) else $error("latch reset did not dominate");
   latch_hold_a: assert property (s_eval_op(ple_pkg::OPC_LATCH) && stk_r[1] && !stk_r[0] |=> latch_r[$past(idx[4:0])]) else $error("latch did not hold set");
   shot_once_a: assert property (s_eval_op(ple_pkg::OPC_POS_SHOT) && stk_r[0] && shot_prev_r[idx[4:0]] |=> !stk_r[0]) else $error("one-shot lasted past one pass");

endmodule
`default_nettype wire

// File: ple_store_model.sv
// Purpose: Settings store that writes a parameter list into the engine
// Assumes: One word per write strobe, addresses from 0 upward
// Notes:   Optional idle gap between words models a slow supplier
`timescale 1ns/1ps
`default_nettype none
module ple_store_model (
   input wire logic clock,
   output logic cfg_we,
   output logic [8:0] cfg_addr,
   output logic [15:0] cfg_data
);
   initial begin
      cfg_we = 1'b0;
      cfg_addr = 9'h000;
      cfg_data = 16'hffff;
   end

   // ****************************************************
   // List download
   // ****************************************************
   // Words leave in list order, operands ahead of users
   task automatic load(input logic [15:0] q[$], input int gap);
      for (int i = 0; i < q.size(); i++) begin
         @(posedge clock);
         cfg_we <= 1'b1;
         cfg_addr <= 9'(i);
         cfg_data <= q[i];
         if (gap > 0) begin
            @(posedge clock);
            cfg_we <= 1'b0;
            cfg_data <= ~q[i];
            repeat (gap - 1) @(posedge clock);
         end
      end
      @(posedge clock);
      // Released lines invert so a stale word is never read as fresh
      cfg_we <= 1'b0;
      cfg_addr <= ~cfg_addr;
      cfg_data <= ~cfg_data;
   endtask
endmodule
`default_nettype wire

// File: ple_engine_bench.sv
// Purpose: Self-checking bench for the postfix logic equation engine
// Assumes: Lists end with END; inputs settle through two sync flops
// Notes:   Each scenario except t_rereset loads its own list, then runs passes
`timescale 1ns/1ps
`default_nettype none
module ple_engine_bench;
   logic clock;
   logic rst;
   logic cfg_we;
   logic [8:0] cfg_addr;
   logic [15:0] cfg_data;
   logic eval_start;
   logic [63:0] input_states;
   logic [15:0] contact_raw;
   logic [15:0] contact_on_state;
   logic [63:0] internal_result_flag;
   logic busy;
   logic pass_done;
   logic syntax_error;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [15:0] prog[$];

   ple_store_model store (.clock(clock), .cfg_we(cfg_we),
      .cfg_addr(cfg_addr), .cfg_data(cfg_data));
   ple_engine dut (.clock(clock), .rst(rst), .cfg_we(cfg_we),
      .cfg_addr(cfg_addr), .cfg_data(cfg_data), .eval_start(eval_start),
      .input_states(input_states), .contact_raw(contact_raw),
      .contact_on_state(contact_on_state),
      .internal_result_flag(internal_result_flag), .busy(busy),
      .pass_done(pass_done), .syntax_error(syntax_error));

   always #2 clock = ~clock;

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run needs under a thousand cycles; this leaves wide margin
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         $display("mismatch at %0t: run hung", $time);
         final_report();
      end
   end

   task automatic chk1(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: flags got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic add(input logic [4:0] op, input int arg);
      prog.push_back({op, 11'(arg)});
   endtask

   task automatic run_pass();
      int n;
      n = 0;
      @(posedge clock) eval_start <= 1'b1;
      @(posedge clock) eval_start <= 1'b0;
      #1;
      chk1(busy, 1'b1, "pass busy");
      while (pass_done !== 1'b1 && n < 2000) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk1(pass_done, 1'b1, "pass end");
   endtask

   task automatic send(input int gap);
      store.load(prog, gap);
      prog.delete();
   endtask

   task automatic drive(input logic [63:0] s, input logic [15:0] c,
                        input logic [15:0] on);
      @(posedge clock);
      input_states <= s;
      contact_raw <= c;
      contact_on_state <= on;
      repeat (3) @(posedge clock);
   endtask

   task automatic go_err(input logic exp);
      send(0);
      run_pass();
      chk1(syntax_error, exp, "syntax error");
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_contact();
      logic [3:0] tab [5] = '{4'b1011, 4'b1110, 4'b1000, 4'b1101, 4'b0010};
      add(ple_pkg::OPC_INPUT, 0);
      add(ple_pkg::OPC_CONTACT, 0);
      add(ple_pkg::OPC_NOT, 0);
      add(ple_pkg::OPC_AND, 2);
      add(ple_pkg::OPC_ASSIGN, 3);
      add(ple_pkg::OPC_END, 0);
      send(0);
      foreach (tab[i]) begin
         drive({63'h0, tab[i][3]}, {15'h0, tab[i][2]}, {15'h0, tab[i][1]});
         run_pass();
         chk1(internal_result_flag[2], tab[i][0], "and-not");
      end
      $display("test contact done");
   endtask

   task automatic t_gates();
      logic [4:0] exp;
      exp = 5'b11001;
      for (int g = 0; g < 4; g++) begin
         for (int i = 0; i < 16; i++) begin
            add(i < 15 ? ple_pkg::OPC_ON : ple_pkg::OPC_OFF, 0);
         end
         add(5'(ple_pkg::OPC_OR + g), 16);
         add(ple_pkg::OPC_ASSIGN, 11 + g);
      end
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_OFF, 0);
      add(ple_pkg::OPC_XOR, 2);
      add(ple_pkg::OPC_ASSIGN, 15);
      add(ple_pkg::OPC_END, 0);
      send(2);
      run_pass();
      for (int g = 0; g < 5; g++) begin
         chk1(internal_result_flag[10 + g], exp[g], "gate");
      end
      $display("test gates done");
   endtask

   task automatic t_latch();
      logic [2:0] tab [5] = '{3'b101, 3'b001, 3'b110, 3'b000, 3'b101};
      add(ple_pkg::OPC_INPUT, 1);
      add(ple_pkg::OPC_INPUT, 2);
      add(ple_pkg::OPC_LATCH, 0);
      add(ple_pkg::OPC_ASSIGN, 5);
      add(ple_pkg::OPC_END, 0);
      send(0);
      foreach (tab[i]) begin
         drive({61'h0, tab[i][1], tab[i][2], 1'b0}, 16'h0, 16'h0);
         run_pass();
         chk1(internal_result_flag[4], tab[i][0], "latch");
      end
      add(ple_pkg::OPC_INPUT, 1);
      send(0);
      drive(64'h0, 16'h0, 16'h0);
      run_pass();
      chk1(internal_result_flag[4], 1'b0, "latch recompile");
      $display("test latch done");
   endtask

   task automatic t_order();
      add(ple_pkg::OPC_FLAG, 7);
      add(ple_pkg::OPC_ASSIGN, 6);
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_ASSIGN, 7);
      add(ple_pkg::OPC_END, 0);
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_ASSIGN, 2);
      add(ple_pkg::OPC_END, 0);
      send(0);
      run_pass();
      chk1(internal_result_flag[5], 1'b0, "feedback first");
      chk1(internal_result_flag[6], 1'b1, "flag seven");
      chk1(internal_result_flag[1], 1'b0, "after end");
      run_pass();
      chk1(internal_result_flag[5], 1'b1, "feedback second");
      $display("test order done");
   endtask

   task automatic t_shot();
      logic [3:0] tab [5] = '{4'b0000, 4'b1101, 4'b1000, 4'b0110, 4'b0000};
      for (int k = 0; k < 3; k++) begin
         add(ple_pkg::OPC_INPUT, 3);
         add(5'(ple_pkg::OPC_POS_SHOT + k), k);
         add(ple_pkg::OPC_ASSIGN, 8 + k);
      end
      add(ple_pkg::OPC_END, 0);
      send(0);
      foreach (tab[i]) begin
         drive({60'h0, tab[i][3], 3'h0}, 16'h0, 16'h0);
         run_pass();
         chk1(internal_result_flag[7], tab[i][0], "pos shot");
         chk1(internal_result_flag[8], tab[i][1], "neg shot");
         chk1(internal_result_flag[9], tab[i][2], "dual shot");
      end
      $display("test shot done");
   endtask

   task automatic t_syntax();
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_ASSIGN, 1);
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_ASSIGN, 1);
      add(ple_pkg::OPC_END, 0);
      go_err(1'b1);
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_TIMER, 3);
      add(ple_pkg::OPC_TIMER, 3);
      add(ple_pkg::OPC_ASSIGN, 1);
      add(ple_pkg::OPC_END, 0);
      go_err(1'b1);
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_AND, 2);
      add(ple_pkg::OPC_ASSIGN, 1);
      add(ple_pkg::OPC_END, 0);
      go_err(1'b1);
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_ASSIGN, 65);
      add(ple_pkg::OPC_END, 0);
      go_err(1'b1);
      repeat (17) add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_OR, 17);
      add(ple_pkg::OPC_ASSIGN, 1);
      add(ple_pkg::OPC_END, 0);
      go_err(1'b1);
      // Unchanged list with a standing error: pass refused at once
      @(posedge clock) eval_start <= 1'b1;
      @(posedge clock) eval_start <= 1'b0;
      #1;
      chk1(pass_done, 1'b1, "refused pass");
      chk1(busy, 1'b0, "refused busy");
      chk1(syntax_error, 1'b1, "error held");
      add(ple_pkg::OPC_ON, 0);
      add(ple_pkg::OPC_TIMER, 3);
      add(ple_pkg::OPC_ASSIGN, 1);
      add(ple_pkg::OPC_END, 0);
      go_err(1'b0);
      chk1(internal_result_flag[0], 1'b1, "timer flag");
      $display("test syntax done");
   endtask

   task automatic t_rereset();
      @(posedge clock) rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk64(internal_result_flag, 64'h0);
      chk1(busy, 1'b0, "busy");
      $display("test power-up done");
   endtask

   initial begin
      clock = 1'b0;
      rst = 1'b1;
      eval_start = 1'b0;
      input_states = 64'h0;
      contact_raw = 16'h0;
      contact_on_state = 16'h0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk64(internal_result_flag, 64'h0);
      chk1(syntax_error, 1'b0, "reset error");
      t_contact();
      t_gates();
      t_latch();
      t_order();
      t_shot();
      t_syntax();
      t_rereset();
      final_report();
   end
endmodule
`default_nettype wire
